// [sleep_wake_status_control.sv]
// How it works
// R1 - Power-down flag cleared by power-up or watchdog clear, set by sleep.
// R2 - Time-out flag cleared by power-up, watchdog clear or sleep; set on time-out.
// R3 - Flag register is never pushed automatically; software saves it.
// R4 - Bits 7-6 read zero; time-out and power-down read-only; low four read/write.
// R5 - Overflow set when carry into and out of msb differ.
// R6 - Zero flag follows whether the result equals zero.
// R7 - Half carry set on low-nibble carry, or no nibble borrow on subtract.
// R8 - Carry set on add carry or subtract no-borrow; rotate updates it too.
// R9 - Fast oscillator clocks the system; slow one clocks watchdog and timer.
// R10 - In sleep the system clock stops; slow oscillator keeps the watchdog alive.
// R11 - Slow oscillator may stop in sleep when watchdog and timer are off.
// R12 - Only the sleep instruction enters power-down; execution halts there.
// R13 - Memory, registers and ports hold their state during power-down.
// R14 - Sleep with watchdog enabled clears the watchdog counter, which keeps counting.
// R15 - Wake on external reset, port A fall, interrupt or watchdog overflow.
// R16 - External-reset wake resets fully; watchdog wake starts a watchdog reset.
// R17 - Watchdog wake sets time-out, resets only program counter and stack pointer.
// R18 - Port A pins 0-2 and 5 individually enabled to wake on falling edge.
// R19 - Disabled interrupt or full stack: resume after sleep, interrupt stays pending.
// R20 - Enabled interrupt with free stack: normal interrupt response on wake.
// R21 - An interrupt already flagged at sleep entry does not wake the device.
// R22 - Wake waits sixteen system clocks; external reset adds about fifty ms first.
// R23 - Software writes never change time-out or power-down flags.
// R24 - Running watchdog time-out resets the device and sets time-out flag.
// R25 - Settle delay counted after fast oscillator restarts; fetch stalled till done.
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
module sleep_wake_status_control #(
   parameter int unsigned RESET_DELAY = sleep_wake_pkg::RESET_DELAY_CYC
) (
   input  wire logic       clock,             // System clock from fast oscillator
   input  wire logic       arst_n,            // Power-on reset, active low
   input  wire logic       ext_reset_n,       // External reset pin, active low
   input  wire logic [7:0] port_a_pins,       // Port A pin levels
   input  wire logic       sleep_instr,       // Sleep instruction executed
   input  wire logic       wdt_clear_instr,   // Watchdog clear instruction executed
   input  wire logic       wdt_timeout,       // Watchdog overflow, slow domain level
   input  wire logic [7:0] irq_flags,         // Interrupt request flags
   input  wire logic [7:0] irq_enables,       // Interrupt enables
   input  wire logic       stack_full,        // Stack has no free level
   input  wire logic       alu_valid,         // ALU result updates flags
   input  wire logic [7:0] alu_result,        // ALU result
   input  wire logic       alu_carry,         // Carry or no-borrow out
   input  wire logic       alu_half,          // Half carry or nibble no-borrow
   input  wire logic       alu_carry_in_msb,  // Carry into bit 7
   input  wire logic       alu_rotate,        // Rotate through carry
   input  wire logic [3:0] reg_addr,          // Register address
   input  wire logic [7:0] reg_wdata,         // Register write data
   input  wire logic       reg_write,         // Register write strobe
   input  wire logic       reg_read,          // Register read strobe
   output logic      [7:0] reg_rdata,         // Read data, one cycle later
   output logic            sys_clock_enable,  // Gate for the fast oscillator
   output logic            slow_osc_enable,   // Gate for the slow oscillator
   output logic            fetch_stall,       // Hold instruction fetch
   output logic            wdt_counter_clear, // Clear watchdog counter
   output logic            full_reset,        // Whole-system reset request
   output logic            pc_sp_reset,       // Reset program counter and stack ptr
   output logic            irq_take,          // Take interrupt response on wake
   output logic [7:0]      flags              // Flag register to the core
);
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic [7:0] pa_level;
   logic [7:0] pa_fall;
   logic       ext_level;
   logic       ext_fall;
   logic       wdt_level;
   logic       wdt_prev;
   logic       wdt_event;

   for (genvar i = 0; i < 8; i++) begin : g_pa
      edge_sync u_pa (
         .clock  (clock),
         .arst_n (arst_n),
         .pin    (port_a_pins[i]),
         .level  (pa_level[i]),
         .fall   (pa_fall[i])
      );
   end

   edge_sync u_ext (
      .clock  (clock),
      .arst_n (arst_n),
      .pin    (ext_reset_n),
      .level  (ext_level),
      .fall   (ext_fall)
   );

   // Watchdog overflow arrives from the slow domain, inverted so fall = rise
   edge_sync u_wdt (
      .clock  (clock),
      .arst_n (arst_n),
      .pin    (~wdt_timeout),
      .level  (wdt_level),
      .fall   (wdt_event)
   );

   assign wdt_prev = ~wdt_level;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] wake_enable;
   logic [7:0] ctrl;
   logic [7:0] irq_at_sleep;
   logic       wr_flags;

   assign wr_flags = reg_write && reg_addr == sleep_wake_pkg::ADDR_FLAGS;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wake_enable <= sleep_wake_pkg::WAKE_EN_RST;
         ctrl        <= sleep_wake_pkg::CTRL_RST;
      end else if (reg_write) begin
         if (reg_addr == sleep_wake_pkg::ADDR_WAKE_EN) begin
            wake_enable <= reg_wdata & sleep_wake_pkg::WAKE_EN_MASK; // R18
         end
         if (reg_addr == sleep_wake_pkg::ADDR_CTRL) begin
            ctrl <= reg_wdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   sleep_wake_pkg::power_state_e state;
   logic [22:0] count;
   logic        irq_wake;
   logic        pa_wake;
   logic        ext_reset_seen;
   logic        wdt_wake;

   assign pa_wake  = |(pa_fall & wake_enable);                  // R18
   assign irq_wake = |(irq_flags & ~irq_at_sleep);              // R21
   assign wdt_wake = wdt_event && ctrl[sleep_wake_pkg::CTRL_WDT_EN];
   assign ext_reset_seen = ext_fall || !ext_level;

   // The fast clock gate is an output only; this logic itself idles in
   // sleep but keeps running so wake sources can be seen at all.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state        <= sleep_wake_pkg::ST_RUN;
         count        <= '0;
         irq_at_sleep <= 8'h00;
         irq_take     <= 1'b0;
         full_reset   <= 1'b0;
         pc_sp_reset  <= 1'b0;
      end else begin
         irq_take    <= 1'b0;
         full_reset  <= 1'b0;
         pc_sp_reset <= 1'b0;
         unique case (state)
            sleep_wake_pkg::ST_RUN: begin
               if (ext_reset_seen) begin
                  full_reset <= 1'b1;
                  state      <= sleep_wake_pkg::ST_RST_WAIT;
                  count      <= '0;
               end else if (wdt_wake) begin
                  full_reset <= 1'b1;                           // R24
                  state      <= sleep_wake_pkg::ST_SETTLE;
                  count      <= '0;
               end else if (sleep_instr) begin
                  irq_at_sleep <= irq_flags;                    // R21
                  state        <= sleep_wake_pkg::ST_SLEEP;     // R12
               end
            end
            sleep_wake_pkg::ST_SLEEP: begin
               count <= '0;
               if (ext_reset_seen) begin
                  full_reset <= 1'b1;                           // R16
                  state      <= sleep_wake_pkg::ST_RST_WAIT;
               end else if (wdt_wake) begin
                  pc_sp_reset <= 1'b1;                          // R17
                  state       <= sleep_wake_pkg::ST_SETTLE;
               end else if (pa_wake || irq_wake) begin          // R15
                  irq_take <= irq_wake && !stack_full
                              && |(irq_flags & ~irq_at_sleep & irq_enables); // R20 R19
                  state    <= sleep_wake_pkg::ST_SETTLE;
               end
            end
            sleep_wake_pkg::ST_RST_WAIT: begin
               if (!ext_level) begin
                  count <= '0;
               end else if (count >= 23'(RESET_DELAY - 1)) begin // R22
                  count <= '0;
                  state <= sleep_wake_pkg::ST_SETTLE;
               end else begin
                  count <= count + 23'd1;
               end
            end
            sleep_wake_pkg::ST_SETTLE: begin
               if (count >= 23'(sleep_wake_pkg::SETTLE_CYCLES - 1)) begin // R25
                  count <= '0;
                  state <= sleep_wake_pkg::ST_RUN;
               end else begin
                  count <= count + 23'd1;
               end
            end
            default: state <= sleep_wake_pkg::ST_RUN;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Clock gating and stall
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sys_clock_enable  <= 1'b1;
         slow_osc_enable   <= 1'b1;
         fetch_stall       <= 1'b0;
         wdt_counter_clear <= 1'b0;
      end else begin
         sys_clock_enable <= !(state == sleep_wake_pkg::ST_SLEEP && !pa_wake
                               && !irq_wake && !wdt_wake && !ext_reset_seen); // R10 R9
         slow_osc_enable  <= state != sleep_wake_pkg::ST_SLEEP
                             || ctrl[sleep_wake_pkg::CTRL_WDT_EN]
                             || ctrl[sleep_wake_pkg::CTRL_TMR_EN];          // R11
         fetch_stall      <= state != sleep_wake_pkg::ST_RUN
                             || (sleep_instr && !ext_reset_seen && !wdt_wake); // R13 R25
         wdt_counter_clear <= wdt_clear_instr
                              || (sleep_instr && ctrl[sleep_wake_pkg::CTRL_WDT_EN]); // R14
      end
   end

   // ---------------------------------------------------------------
   // Flag register; never stacked by hardware
   // ---------------------------------------------------------------
   logic [3:0] arith;
   logic       to_flag;
   logic       pd_flag;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         to_flag <= 1'b0;
         pd_flag <= 1'b0;
      end else begin
         // Time-out set wins over a clear in the same cycle
         if (wdt_wake) begin
            to_flag <= 1'b1;                                    // R2 R24 R17
         end else if (wdt_clear_instr || sleep_instr) begin
            to_flag <= 1'b0;                                    // R2
         end
         if (sleep_instr && state == sleep_wake_pkg::ST_RUN) begin
            pd_flag <= 1'b1;                                    // R1
         end else if (wdt_clear_instr) begin
            pd_flag <= 1'b0;                                    // R1 R23
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         arith <= sleep_wake_pkg::FLAG_RESET[3:0];
      end else if (wr_flags) begin
         arith <= reg_wdata[3:0];                               // R4 R3 R23
      end else if (alu_rotate) begin
         arith[sleep_wake_pkg::CARRY_BIT] <= alu_carry;         // R8
      end else if (alu_valid) begin
         arith[sleep_wake_pkg::CARRY_BIT] <= alu_carry;         // R8
         arith[sleep_wake_pkg::HALF_BIT]  <= alu_half;          // R7
         arith[sleep_wake_pkg::ZERO_BIT]  <= alu_result == 8'h00; // R6
         arith[sleep_wake_pkg::OVF_BIT]   <= alu_carry_in_msb ^ alu_carry; // R5
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         flags <= sleep_wake_pkg::FLAG_RESET;
      end else begin
         flags <= {2'b00, to_flag, pd_flag, arith};             // R4
      end
   end

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         unique case (reg_addr)
            sleep_wake_pkg::ADDR_FLAGS:   reg_rdata <= {2'b00, to_flag, pd_flag, arith}; // R4
            sleep_wake_pkg::ADDR_WAKE_EN: reg_rdata <= wake_enable;
            sleep_wake_pkg::ADDR_CTRL:    reg_rdata <= ctrl;
            sleep_wake_pkg::ADDR_STATE:   reg_rdata <= {5'b00000, state};
            default:                      reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   logic unused_ok;
   assign unused_ok = wdt_prev;
endmodule // sleep_wake_status_control

// [sleep_wake_pkg.sv]
package sleep_wake_pkg;
   // ---------------------------------------------------------------
   // Flag register layout
   // ---------------------------------------------------------------
   localparam int unsigned CARRY_BIT    = 0;
   localparam int unsigned HALF_BIT     = 1;
   localparam int unsigned ZERO_BIT     = 2;
   localparam int unsigned OVF_BIT      = 3;
   localparam int unsigned PDF_BIT      = 4;
   localparam int unsigned TO_BIT       = 5;
   localparam logic [7:0]  FLAG_RESET   = 8'h00;
   localparam logic [7:0]  ARITH_MASK   = 8'h0F;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [3:0]  ADDR_FLAGS   = 4'h0;
   localparam logic [3:0]  ADDR_WAKE_EN = 4'h1;
   localparam logic [3:0]  ADDR_CTRL    = 4'h2;
   localparam logic [3:0]  ADDR_STATE   = 4'h3;
   localparam logic [7:0]  WAKE_EN_MASK = 8'h27;
   localparam logic [7:0]  WAKE_EN_RST  = 8'h00;
   localparam logic [7:0]  CTRL_RST     = 8'h00;
   localparam int unsigned CTRL_WDT_EN  = 0;
   localparam int unsigned CTRL_TMR_EN  = 1;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLOCK_HZ       = 25_000_000;
   localparam int unsigned SETTLE_CYCLES  = 16;
   localparam int unsigned RESET_DELAY_MS = 50;
   localparam int unsigned RESET_DELAY_CYC = CLOCK_HZ / 1000 * RESET_DELAY_MS;
   // ---------------------------------------------------------------
   // Sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_RUN      = 3'b000,
      ST_SLEEP    = 3'b001,
      ST_RST_WAIT = 3'b010,
      ST_SETTLE   = 3'b011
   } power_state_e;
endpackage

// [edge_sync.sv]
`timescale 1ns/100ps
module edge_sync (
   input  wire logic clock,   // System clock
   input  wire logic arst_n,  // Async reset
   input  wire logic pin,     // Asynchronous pin
   output logic      level,   // Synchronised level
   output logic      fall     // One-cycle falling-edge pulse
);
   logic meta;
   logic prev;

   // Idle high so a high pin at reset is not seen as an edge
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         meta  <= 1'b1;
         level <= 1'b1;
         prev  <= 1'b1;
      end else begin
         meta  <= pin;
         level <= meta;
         prev  <= level;
      end
   end

   assign fall = prev & ~level;
endmodule // edge_sync

// [sleep_wake_status_control_chk.sv]
`timescale 1ns/100ps
module sleep_wake_status_control_chk #(
   parameter int unsigned RESET_DELAY = sleep_wake_pkg::RESET_DELAY_CYC
) (
   input wire logic       clock,            // System clock
   input wire logic       arst_n,           // Power-on reset
   input wire logic       ext_reset_n,      // External reset pin
   input wire logic       sleep_instr,      // Sleep executed
   input wire logic       wdt_clear_instr,  // Watchdog clear executed
   input wire logic [7:0] irq_flags,        // Interrupt requests
   input wire logic [7:0] irq_enables,      // Interrupt enables
   input wire logic       stack_full,       // No free stack level
   input wire logic       reg_read,         // Read strobe
   input wire logic [7:0] reg_rdata,        // Read data
   input wire logic       sys_clock_enable, // Fast clock gate
   input wire logic       fetch_stall,      // Fetch hold
   input wire logic       full_reset,       // Whole reset request
   input wire logic       pc_sp_reset,      // Partial reset request
   input wire logic       irq_take,         // Interrupt response
   input wire logic [7:0] flags             // Flag register
);
   // ---------------------------------------------------------------
   // Sleep, wake and flag relations
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   sequence s_sleep;
      sleep_instr && !fetch_stall;
   endsequence
   // Sixteen held cycles, split since repeats stay short
   sequence s_settle;
      fetch_stall [*8] ##1 fetch_stall [*8];
   endsequence
   a_sleep_stall: assert property (s_sleep |=> fetch_stall)
      else $error("fetch not held after sleep");
   a_sleep_flags: assert property (s_sleep |-> ##2 (flags[4] && !flags[5]))
      else $error("sleep flags wrong");
   a_clear_flags: assert property (wdt_clear_instr |-> ##2 !(flags[4] || flags[5]))
      else $error("clear flags wrong");
   a_upper_zero: assert property (flags[7:6] == 2'b00)
      else $error("upper flag bits set");
   a_rdata_idle: assert property (reg_rdata != 8'h00 |-> $past(reg_read))
      else $error("read data without read");
   a_sleep_gate: assert property (s_sleep ##0 ext_reset_n |-> ##[1:3] !sys_clock_enable)
      else $error("clock not stopped in sleep");
   a_settle_len: assert property ($rose(sys_clock_enable) |-> s_settle)
      else $error("settle shorter than sixteen");
   a_stall_end: assert property ($fell(fetch_stall) |-> sys_clock_enable)
      else $error("fetch released without clock");
   a_wdt_wake: assert property (pc_sp_reset |-> !full_reset ##1 !pc_sp_reset)
      else $error("watchdog wake reset wrong");
   // Response is registered, so judge the inputs of the deciding cycle
   a_irq_take: assert property (irq_take |->
      $past(!stack_full && (irq_flags & irq_enables) != 8'h00))
      else $error("interrupt taken wrongly");
endmodule // sleep_wake_status_control_chk
bind sleep_wake_status_control sleep_wake_status_control_chk #(.RESET_DELAY(RESET_DELAY))
   i_sleep_wake_status_control_chk (.clock(clock), .arst_n(arst_n), .ext_reset_n(ext_reset_n),
   .sleep_instr(sleep_instr), .wdt_clear_instr(wdt_clear_instr), .irq_flags(irq_flags),
   .irq_enables(irq_enables), .stack_full(stack_full), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .sys_clock_enable(sys_clock_enable), .fetch_stall(fetch_stall),
   .full_reset(full_reset), .pc_sp_reset(pc_sp_reset), .irq_take(irq_take), .flags(flags));

// [core_model.sv]
`timescale 1ns/100ps
module core_model (
   input  wire logic clock,           // System clock
   input  wire logic fetch_stall,     // Fetch held by sequencer
   output logic      sleep_instr,     // Sleep executed
   output logic      wdt_clear_instr  // Watchdog clear executed
);
   // ---------------------------------------------------------------
   // Instruction issue
   // ---------------------------------------------------------------
   initial begin
      sleep_instr = 1'b0;
      wdt_clear_instr = 1'b0;
   end
   // A stalled core executes nothing, so issue waits for fetch
   task automatic issue(input logic clr);
      @(posedge clock);
      while (fetch_stall !== 1'b0) begin
         @(posedge clock);
      end
      if (clr) begin
         wdt_clear_instr <= 1'b1;
      end else begin
         sleep_instr <= 1'b1;
      end
      @(posedge clock);
      sleep_instr <= 1'b0;
      wdt_clear_instr <= 1'b0;
   endtask
endmodule // core_model

// [sleep_wake_status_control_tb.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module sleep_wake_status_control_tb;
   localparam int unsigned RST_DLY = 20;
   logic clock = 1'b0, arst_n = 1'b0, ext_reset_n = 1'b1, wdt_timeout = 1'b0, stack_full = 1'b0;
   logic [7:0] port_a_pins = 8'hff, irq_flags = 8'h00, irq_enables = 8'h00;
   logic alu_valid = 1'b0, alu_carry = 1'b0, alu_half = 1'b0, alu_carry_in_msb = 1'b0;
   logic alu_rotate = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
   logic [7:0] alu_result = 8'h00, reg_wdata = 8'h00, reg_rdata, flags;
   logic [3:0] reg_addr = 4'h0;
   logic sleep_instr, wdt_clear_instr, sys_clock_enable, slow_osc_enable, fetch_stall;
   logic wdt_counter_clear, full_reset, pc_sp_reset, irq_take;
   logic seen_pcsp, seen_full, seen_take;
   int   stall_n, num_errors = 0, checked = 0;
   always #20 clock = ~clock;
   sleep_wake_status_control #(.RESET_DELAY(RST_DLY)) i_sleep_wake_status_control (
      .clock(clock), .arst_n(arst_n), .ext_reset_n(ext_reset_n), .port_a_pins(port_a_pins),
      .sleep_instr(sleep_instr), .wdt_clear_instr(wdt_clear_instr), .wdt_timeout(wdt_timeout),
      .irq_flags(irq_flags), .irq_enables(irq_enables), .stack_full(stack_full),
      .alu_valid(alu_valid), .alu_result(alu_result), .alu_carry(alu_carry),
      .alu_half(alu_half), .alu_carry_in_msb(alu_carry_in_msb), .alu_rotate(alu_rotate),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .sys_clock_enable(sys_clock_enable),
      .slow_osc_enable(slow_osc_enable), .fetch_stall(fetch_stall),
      .wdt_counter_clear(wdt_counter_clear), .full_reset(full_reset),
      .pc_sp_reset(pc_sp_reset), .irq_take(irq_take), .flags(flags));
   core_model i_core_model (.clock(clock), .fetch_stall(fetch_stall), .sleep_instr(sleep_instr),
      .wdt_clear_instr(wdt_clear_instr));
   // ---------------------------------------------------------------
   // Bus, ALU and observation helpers
   // ---------------------------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      @(negedge clock);
      `CHK(reg_rdata, e)
   endtask
   task automatic alu(input logic v, input logic [7:0] r, input logic c, h, m, input logic [3:0] e);
      @(posedge clock);
      alu_valid <= v;
      alu_rotate <= !v;
      alu_result <= r;
      alu_carry <= c;
      alu_half <= h;
      alu_carry_in_msb <= m;
      @(posedge clock);
      alu_valid <= 1'b0;
      alu_rotate <= 1'b0;
      repeat (2) @(negedge clock);
      `CHK(flags[3:0], e)
   endtask
   task automatic watch(input int lim);
      {seen_pcsp, seen_full, seen_take, stall_n} = '0;
      repeat (lim) begin
         @(negedge clock);
         seen_pcsp |= pc_sp_reset;
         seen_full |= full_reset;
         seen_take |= irq_take;
         stall_n += int'(fetch_stall);
      end
   endtask
   // Wake sources are held off until the clock gate has dropped
   task automatic nap;
      i_core_model.issue(1'b0);
      repeat (4) @(negedge clock);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs;
      @(negedge clock);
      `CHK(flags, 8'h00)
      `CHK({sys_clock_enable, slow_osc_enable}, 2'b11)
      rd(sleep_wake_pkg::ADDR_CTRL, 8'h00);
      wr(sleep_wake_pkg::ADDR_FLAGS, 8'hff);
      rd(sleep_wake_pkg::ADDR_FLAGS, 8'h0f);
      rd(4'h9, 8'h00);
      wr(sleep_wake_pkg::ADDR_WAKE_EN, 8'hff);
      rd(sleep_wake_pkg::ADDR_WAKE_EN, 8'h27);
      alu(1'b1, 8'h00, 1'b1, 1'b1, 1'b0, 4'hf);
      alu(1'b1, 8'h80, 1'b0, 1'b0, 1'b1, 4'h8);
      alu(1'b0, 8'h00, 1'b1, 1'b0, 1'b0, 4'h9);
      alu(1'b1, 8'h7f, 1'b1, 1'b0, 1'b1, 4'h1);
   endtask
   task automatic t_port;
      wr(sleep_wake_pkg::ADDR_CTRL, 8'h01);
      i_core_model.issue(1'b0);
      @(negedge clock);
      `CHK(wdt_counter_clear, 1'b1)
      repeat (3) @(negedge clock);
      `CHK(flags, 8'h11)
      `CHK({fetch_stall, sys_clock_enable}, 2'b10)
      rd(sleep_wake_pkg::ADDR_STATE, {5'h00, sleep_wake_pkg::ST_SLEEP});
      @(posedge clock);
      port_a_pins <= 8'hf7;
      watch(10);
      `CHK(fetch_stall, 1'b1)
      @(posedge clock);
      port_a_pins <= 8'hd7;
      watch(40);
      `CHK({fetch_stall, seen_take, seen_pcsp, seen_full}, 4'h0)
      `CHK(1'(stall_n >= 16), 1'b1)
      `CHK(flags, 8'h11)
      @(posedge clock);
      port_a_pins <= 8'hff;
   endtask
   task automatic t_wdt;
      nap();
      @(posedge clock);
      wdt_timeout <= 1'b1;
      watch(40);
      `CHK({seen_pcsp, seen_full, fetch_stall}, 3'b100)
      `CHK(flags, 8'h31)
      @(posedge clock);
      wdt_timeout <= 1'b0;
      i_core_model.issue(1'b1);
      repeat (2) @(negedge clock);
      `CHK(flags, 8'h01)
      @(posedge clock);
      wdt_timeout <= 1'b1;
      watch(10);
      `CHK({seen_full, flags[5]}, 2'b11)
      @(posedge clock);
      wdt_timeout <= 1'b0;
   endtask
   task automatic t_irq;
      @(posedge clock);
      irq_flags <= 8'h01;
      irq_enables <= 8'h02;
      nap();
      `CHK(flags, 8'h11)
      watch(10);
      `CHK(fetch_stall, 1'b1)
      @(posedge clock);
      irq_flags <= 8'h03;
      watch(40);
      `CHK({seen_take, fetch_stall}, 2'b10)
      @(posedge clock);
      irq_flags <= 8'h00;
      stack_full <= 1'b1;
      nap();
      @(posedge clock);
      irq_flags <= 8'h02;
      watch(40);
      `CHK({seen_take, fetch_stall}, 2'b00)
      @(posedge clock);
      {irq_flags, stack_full} <= 9'h000;
   endtask
   task automatic t_ext;
      wr(sleep_wake_pkg::ADDR_CTRL, 8'h00);
      nap();
      `CHK(slow_osc_enable, 1'b0)
      @(posedge clock);
      ext_reset_n <= 1'b0;
      // Reset request is a one-cycle pulse while the pin is still low
      watch(6);
      `CHK(seen_full, 1'b1)
      @(posedge clock);
      ext_reset_n <= 1'b1;
      watch(80);
      `CHK(fetch_stall, 1'b0)
      `CHK(1'(stall_n >= RST_DLY + 16), 1'b1)
   endtask
   task automatic test_done;
      $display("errors=%0d checks=%0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clock);
      arst_n <= 1'b1;
      t_regs();
      t_port();
      t_wdt();
      t_irq();
      t_ext();
      test_done();
   end
   // Whole run is well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clock);
      num_errors++;
      test_done();
   end
endmodule // sleep_wake_status_control_tb
